// ### src/pmcp_pkg.sv
package pmcp_pkg;
    // Address map of the protected spaces
    localparam logic [21:0] BOOT_END   = 22'h0001ff;
    localparam logic [21:0] BLK0_BASE  = 22'h000200;
    localparam logic [21:0] USER_END   = 22'h007fff;
    localparam logic [21:0] ID_BASE    = 22'h200000;
    localparam logic [21:0] ID_END     = 22'h200007;
    localparam logic [21:0] CFG_BASE   = 22'h300006;
    localparam logic [21:0] CFG_END    = 22'h30000d;
    localparam logic [21:0] DEVID_BASE = 22'h3ffffe;
    localparam logic [21:0] DEVID_END  = 22'h3fffff;
    // Block decode: four blocks on 8 KB boundaries plus the boot block
    localparam int          BLK_LSB    = 13;
    localparam logic [2:0]  BOOT_IDX   = 3'h4;
    localparam int          NBLK       = 5;
    localparam int          NCFG       = 8;
    // Protection register offsets
    localparam logic [21:0] FUSE_MODE_OFS    = 22'h300006;
    localparam logic [21:0] BLK_CP_OFS       = 22'h300008;
    localparam logic [21:0] BOOT_EE_CP_OFS   = 22'h300009;
    localparam logic [21:0] BLK_WP_OFS       = 22'h30000a;
    localparam logic [21:0] BOOT_EE_CFG_WP_OFS = 22'h30000b;
    localparam logic [21:0] BLK_TRP_OFS      = 22'h30000c;
    localparam logic [21:0] BOOT_TRP_OFS     = 22'h30000d;
    // Byte indices within the configuration window
    localparam logic [2:0]  IX_FUSE  = 3'h0;
    localparam logic [2:0]  IX_CP    = 3'h2;
    localparam logic [2:0]  IX_BCP   = 3'h3;
    localparam logic [2:0]  IX_WP    = 3'h4;
    localparam logic [2:0]  IX_BWP   = 3'h5;
    localparam logic [2:0]  IX_TRP   = 3'h6;
    localparam logic [2:0]  IX_BTRP  = 3'h7;
    // Field positions
    localparam int EE_CP_BIT   = 7;
    localparam int BOOT_BIT    = 6;
    localparam int EE_WP_BIT   = 7;
    localparam int CFG_WP_BIT  = 5;
    localparam int LVP_BIT     = 2;
    localparam int DEBUG_BIT   = 7;
    // Implemented bits per byte; unimplemented bits read zero
    localparam logic [7:0] CFG_MASK [NCFG] =
        '{8'h84, 8'h00, 8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
    // Bits that only the programmer may clear
    localparam logic [7:0] PGM_ONLY [NCFG] =
        '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    // Bits that change only in a high-voltage session
    localparam logic [7:0] HV_ONLY [NCFG] =
        '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [21:0] addr;
        logic [21:0] pc;
        logic [7:0]  wdata;
    } pmcp_cpu_req_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic        ee;
        logic        chip_erase;
        logic        block_erase;
        logic [2:0]  blk;
        logic [21:0] addr;
        logic [7:0]  wdata;
    } pmcp_pgm_req_t;

    typedef struct packed {
        logic       ack;
        logic       allow;
        logic [7:0] rdata;
    } pmcp_rsp_t;
endpackage

// ### src/pmcp_guard.sv
// How it works
// - Bytes 000000h-0001FFh form the boot block with its own three bits.
// - Remaining memory decodes into four blocks at 200h, 2000h, 4000h, 6000h to 7FFFh.
// - Each of five blocks has code, write and table-read protect bits.
// - Code protect ignored for CPU; cleared bit blocks programmer reads and writes.
// - CPU table writes refused into a block whose write protect is 0.
// - Table-read bit 0: same-block reads get data, foreign reads return zeros.
// - Table access reaches user memory, device ID reads, config reads and writes.
// - Writes only clear protection bits; writing 1 over 0 keeps 0.
// - Bits return to 1 only by chip or block erase from the programmer.
// - EEPROM code protect blocks all programmer EEPROM reads and writes.
// - EEPROM write protect blocks programmer EEPROM writes, not reads.
// - CPU may always read and write the data EEPROM.
// - Config write protect guards config bytes against CPU writes only; CPU cannot change it.
// - Eight ID bytes 200000h-200007h are table accessible and always readable.
// - Debug bit 0 enables debug and reserves its pins and memory.
// - Low-voltage bit set dedicates entry pin; pin high enters programming.
// - Low-voltage enable reads 1 in an unprogrammed part.
// - High-voltage entry on master clear always accepted.
// - Low-voltage bit changes only in high-voltage sessions; 0 frees the pin.
`timescale 1ns/1ps
`default_nettype none
module pmcp_guard (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire pmcp_pkg::pmcp_cpu_req_t cpu_req,
    input  wire logic [7:0]             mem_rdata,
    input  wire pmcp_pkg::pmcp_pgm_req_t pgm_req,
    input  wire logic [7:0]             pgm_mem_rdata,
    input  wire logic                   prog_entry_pin,
    input  wire logic                   master_clear_prog_voltage_pin,
    output var  pmcp_pkg::pmcp_rsp_t    cpu_rsp,
    output var  pmcp_pkg::pmcp_rsp_t    pgm_rsp,
    output logic                        prog_mode,
    output logic                        prog_pin_is_gpio,
    output logic                        debug_enable,
    output logic                        ee_cpu_allow
);
    // Pin synchronisers: first stage feeds only the second
    logic [2:0] pgm_pin_sync_reg;
    logic [2:0] hv_pin_sync_reg;
    logic       pgm_lvl_reg;
    logic       hv_lvl_reg;
    always_ff @(posedge sys_clk) begin
        pgm_pin_sync_reg <= {pgm_pin_sync_reg[1:0], prog_entry_pin};
        hv_pin_sync_reg  <= {hv_pin_sync_reg[1:0], master_clear_prog_voltage_pin};
    end

    // A level counts only once the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pgm_lvl_reg <= 1'b0;
            hv_lvl_reg  <= 1'b0;
        end else begin
            if (pgm_pin_sync_reg[1] == pgm_pin_sync_reg[2]) begin
                pgm_lvl_reg <= pgm_pin_sync_reg[2];
            end
            if (hv_pin_sync_reg[1] == hv_pin_sync_reg[2]) begin
                hv_lvl_reg <= hv_pin_sync_reg[2];
            end
        end
    end

    // Block index: boot block below 200h, else address bits 14:13
    function automatic logic [2:0] blk_of(input logic [21:0] a);
        if (a <= pmcp_pkg::BOOT_END) begin
            blk_of = pmcp_pkg::BOOT_IDX;
        end else begin
            blk_of = {1'b0, a[pmcp_pkg::BLK_LSB+1:pmcp_pkg::BLK_LSB]};
        end
    endfunction

    // Protection bytes as seen by everyone
    logic [7:0]          cfg_vec [pmcp_pkg::NCFG];
    logic [pmcp_pkg::NBLK-1:0] cp_bits;
    logic [pmcp_pkg::NBLK-1:0] wp_bits;
    logic [pmcp_pkg::NBLK-1:0] trp_bits;
    wire logic ee_cp  = cfg_vec[pmcp_pkg::IX_BCP][pmcp_pkg::EE_CP_BIT];
    wire logic ee_wp  = cfg_vec[pmcp_pkg::IX_BWP][pmcp_pkg::EE_WP_BIT];
    wire logic cfg_wp = cfg_vec[pmcp_pkg::IX_BWP][pmcp_pkg::CFG_WP_BIT];
    wire logic lvp_en = cfg_vec[pmcp_pkg::IX_FUSE][pmcp_pkg::LVP_BIT];
    wire logic dbg_n  = cfg_vec[pmcp_pkg::IX_FUSE][pmcp_pkg::DEBUG_BIT];
    // Three bits per block, boot block at index four
    assign cp_bits  = {cfg_vec[pmcp_pkg::IX_BCP][pmcp_pkg::BOOT_BIT],
                       cfg_vec[pmcp_pkg::IX_CP][3:0]};
    assign wp_bits  = {cfg_vec[pmcp_pkg::IX_BWP][pmcp_pkg::BOOT_BIT],
                       cfg_vec[pmcp_pkg::IX_WP][3:0]};
    assign trp_bits = {cfg_vec[pmcp_pkg::IX_BTRP][pmcp_pkg::BOOT_BIT],
                       cfg_vec[pmcp_pkg::IX_TRP][3:0]};

    // CPU side address classes
    wire logic        cpu_user  = cpu_req.addr <= pmcp_pkg::USER_END;
    wire logic        cpu_id    = cpu_req.addr >= pmcp_pkg::ID_BASE &&
                                  cpu_req.addr <= pmcp_pkg::ID_END;
    wire logic        cpu_cfg   = cpu_req.addr >= pmcp_pkg::CFG_BASE &&
                                  cpu_req.addr <= pmcp_pkg::CFG_END;
    wire logic        cpu_devid = cpu_req.addr >= pmcp_pkg::DEVID_BASE;
    wire logic [21:0] cpu_off   = cpu_req.addr - pmcp_pkg::CFG_BASE;
    wire logic [2:0]  cpu_tgt   = blk_of(cpu_req.addr);
    wire logic [2:0]  cpu_src   = blk_of(cpu_req.pc);
    wire logic        same_blk  = cpu_req.pc <= pmcp_pkg::USER_END &&
                                  cpu_tgt == cpu_src;
    // Code protect plays no part here: it only guards the programmer path
    wire logic cpu_rd_ok = cpu_user ? (trp_bits[cpu_tgt] | same_blk) : 1'b1;
    wire logic cpu_wr_ok = cpu_user ? wp_bits[cpu_tgt] :
                           cpu_id   ? 1'b1 :
                           cpu_cfg  ? cfg_wp : 1'b0;
    wire logic [7:0] cpu_src_data =
        (cpu_user || cpu_id || cpu_devid) ? mem_rdata :
        cpu_cfg ? cfg_vec[cpu_off[2:0]] : 8'h00;
    wire logic [7:0] cpu_rd_data = cpu_rd_ok ? cpu_src_data : 8'h00;
    wire logic cpu_cfg_clr = cpu_req.valid && cpu_req.wr && cpu_cfg && cfg_wp;

    // Programmer side: only acts inside a programming session
    wire logic        pgm_act   = pgm_req.valid && prog_mode;
    wire logic        pgm_user  = pgm_req.addr <= pmcp_pkg::USER_END;
    wire logic        pgm_id    = pgm_req.addr >= pmcp_pkg::ID_BASE &&
                                  pgm_req.addr <= pmcp_pkg::ID_END;
    wire logic        pgm_cfg   = pgm_req.addr >= pmcp_pkg::CFG_BASE &&
                                  pgm_req.addr <= pmcp_pkg::CFG_END;
    wire logic        pgm_devid = pgm_req.addr >= pmcp_pkg::DEVID_BASE;
    wire logic [21:0] pgm_off   = pgm_req.addr - pmcp_pkg::CFG_BASE;
    wire logic [2:0]  pgm_tgt   = blk_of(pgm_req.addr);
    wire logic pgm_rd_ok = pgm_req.ee ? ee_cp :
                           pgm_user   ? cp_bits[pgm_tgt] :
                           1'b1;
    wire logic pgm_wr_ok = pgm_req.ee ? (ee_cp & ee_wp) :
                           pgm_user   ? (cp_bits[pgm_tgt] & wp_bits[pgm_tgt]) :
                           (pgm_id || pgm_cfg);
    wire logic [7:0] pgm_src_data =
        (pgm_req.ee || pgm_user || pgm_id || pgm_devid) ? pgm_mem_rdata :
        pgm_cfg ? cfg_vec[pgm_off[2:0]] : 8'h00;
    wire logic [7:0] pgm_rd_data = pgm_rd_ok ? pgm_src_data : 8'h00;
    wire logic pgm_cfg_clr = pgm_act && pgm_req.wr && !pgm_req.ee && pgm_cfg;
    wire logic chip_erase  = pgm_act && pgm_req.chip_erase;
    wire logic block_erase = pgm_act && pgm_req.block_erase && pgm_req.blk <= pmcp_pkg::BOOT_IDX;

    // Protection bytes: held through srst, erased state has every implemented bit at one
    genvar gi;
    generate
        for (gi = 0; gi < pmcp_pkg::NCFG; gi++) begin : g_cfg
            logic [7:0] byte_reg = pmcp_pkg::CFG_MASK[gi];
            wire logic [7:0] cpu_wm = pmcp_pkg::CFG_MASK[gi] & ~pmcp_pkg::PGM_ONLY[gi];
            wire logic [7:0] pgm_wm = pmcp_pkg::CFG_MASK[gi] &
                                      (hv_lvl_reg ? 8'hff : ~pmcp_pkg::HV_ONLY[gi]);
            wire logic cpu_hit = cpu_cfg_clr && cpu_off[2:0] == 3'(gi);
            wire logic pgm_hit = pgm_cfg_clr && pgm_off[2:0] == 3'(gi);
            wire logic [7:0] cpu_keep = cpu_hit ? (cpu_req.wdata | ~cpu_wm) : 8'hff;
            wire logic [7:0] pgm_keep = pgm_hit ? (pgm_req.wdata | ~pgm_wm) : 8'hff;
            wire logic blk_byte = (3'(gi) == pmcp_pkg::IX_CP || 3'(gi) == pmcp_pkg::IX_WP ||
                                   3'(gi) == pmcp_pkg::IX_TRP);
            wire logic boot_byte = (3'(gi) == pmcp_pkg::IX_BCP || 3'(gi) == pmcp_pkg::IX_BWP ||
                                    3'(gi) == pmcp_pkg::IX_BTRP);
            wire logic [7:0] blk_set =
                !block_erase ? 8'h00 :
                (pgm_req.blk == pmcp_pkg::BOOT_IDX) ?
                    (boot_byte ? (8'h01 << pmcp_pkg::BOOT_BIT) : 8'h00) :
                    (blk_byte ? (8'h01 << pgm_req.blk[1:0]) : 8'h00);
            wire logic [7:0] set_bits = chip_erase ? pmcp_pkg::CFG_MASK[gi] : blk_set;
            // Erase wins over a same-cycle clear
            wire logic [7:0] byte_next = ((byte_reg & cpu_keep & pgm_keep) | set_bits) &
                                         pmcp_pkg::CFG_MASK[gi];
            always_ff @(posedge sys_clk) begin
                byte_reg <= byte_next;
            end
            assign cfg_vec[gi] = byte_reg;
        end
    endgenerate

    // Registered answers, one cycle after each request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_rsp <= '0;
            pgm_rsp <= '0;
        end else begin
            cpu_rsp.ack   <= cpu_req.valid;
            cpu_rsp.allow <= cpu_req.valid && (cpu_req.wr ? cpu_wr_ok : cpu_rd_ok);
            cpu_rsp.rdata <= (cpu_req.valid && !cpu_req.wr) ? cpu_rd_data : 8'h00;
            pgm_rsp.ack   <= pgm_act;
            pgm_rsp.allow <= pgm_act && (pgm_req.chip_erase || pgm_req.block_erase ||
                             (pgm_req.wr ? pgm_wr_ok : pgm_rd_ok));
            pgm_rsp.rdata <= (pgm_act && !pgm_req.wr) ? pgm_rd_data : 8'h00;
        end
    end

    // Mode outputs: high voltage always enters, low voltage only when enabled
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prog_mode        <= 1'b0;
            prog_pin_is_gpio <= 1'b0;
            debug_enable     <= 1'b0;
            ee_cpu_allow     <= 1'b0;
        end else begin
            prog_mode        <= hv_lvl_reg | (lvp_en & pgm_lvl_reg);
            prog_pin_is_gpio <= ~lvp_en;
            debug_enable     <= ~dbg_n;
            ee_cpu_allow     <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic [63:0] cfg_flat = {cfg_vec[7], cfg_vec[6], cfg_vec[5], cfg_vec[4],
                                  cfg_vec[3], cfg_vec[2], cfg_vec[1], cfg_vec[0]};
    wire logic cpu_foreign = cpu_req.valid && !cpu_req.wr && cpu_user &&
                             !trp_bits[cpu_tgt] && !same_blk;

    a_foreign_read_zero: assert property (cpu_foreign |=> !cpu_rsp.allow && cpu_rsp.rdata == 8'h00)
        else $error("foreign table read not zeroed");
    a_write_protect_cpu: assert property (cpu_req.valid && cpu_req.wr && cpu_user &&
                                          !wp_bits[cpu_tgt] |=> cpu_rsp.ack && !cpu_rsp.allow)
        else $error("protected table write allowed");
    a_bits_only_clear: assert property (!chip_erase && !block_erase |=> (cfg_flat & ~$past(cfg_flat)) == 64'h0)
        else $error("protection bit set without erase");
    a_ee_code_prot: assert property (pgm_act && pgm_req.ee && !ee_cp |=> !pgm_rsp.allow)
        else $error("eeprom access while code protected");
    a_ee_write_prot: assert property (pgm_act && pgm_req.ee && pgm_req.wr && !ee_wp
                                      |=> pgm_rsp.ack && !pgm_rsp.allow)
        else $error("eeprom write while write protected");
    a_cfg_wp_cpu: assert property (!pgm_act |=> $stable(cfg_wp))
        else $error("config write protect changed by cpu");
    a_id_readable: assert property (pgm_act && !pgm_req.wr && !pgm_req.ee && pgm_id
                                    |=> pgm_rsp.allow && pgm_rsp.rdata == $past(pgm_mem_rdata))
        else $error("id location not readable");
    a_hv_entry: assert property (hv_lvl_reg |=> prog_mode)
        else $error("high voltage entry refused");
    a_lvp_hv_only: assert property ($changed(lvp_en) |-> $past(hv_lvl_reg) || $past(chip_erase))
        else $error("low voltage bit changed outside hv session");
    a_cp_user_ignored: assert property (cpu_req.valid && !cpu_req.wr && cpu_user && trp_bits[cpu_tgt]
                                        |=> cpu_rsp.allow ##1 1'b1)
        else $error("cpu read blocked by code protect");
    a_unimpl_zero: assert property (cpu_req.valid && !cpu_req.wr && !cpu_user && !cpu_id &&
                                    !cpu_cfg && !cpu_devid |=> cpu_rsp.rdata == 8'h00)
        else $error("unimplemented space read nonzero");
    a_debug_follow: assert property ($fell(dbg_n) |-> ##1 debug_enable)
        else $error("debug not enabled");

    c_foreign_read: cover property (cpu_foreign ##1 cpu_rsp.ack);
    c_block_erase:  cover property (block_erase ##1 $rose(cfg_flat[pmcp_pkg::BOOT_BIT + 24]));
    c_lvp_entry:    cover property (lvp_en && pgm_lvl_reg && !hv_lvl_reg ##1 prog_mode);
endmodule // pmcp_guard
`default_nettype wire

// ### bench/pmcp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the flash array and data EEPROM behind the guard.
// Every byte carries its low address byte XOR a pattern, nonzero except where that byte equals the pattern.
// Space above the last block is not zeroed here; that is the guard's job
module pmcp_mem_model (
    input  wire logic [21:0] cpu_addr,
    input  wire logic [21:0] pgm_addr,
    input  wire logic        pgm_ee,
    output logic      [7:0]  cpu_data,
    output logic      [7:0]  pgm_data
);
    // Flash bytes use one pattern and EEPROM bytes another
    assign cpu_data = cpu_addr[7:0] ^ 8'h5a;
    assign pgm_data = pgm_addr[7:0] ^ (pgm_ee ? 8'ha5 : 8'h5a);
endmodule // pmcp_mem_model
`default_nettype wire

// ### bench/test_program_memory_code_protection.sv
`timescale 1ns/1ps
`default_nettype none
module test_program_memory_code_protection;
    logic                    sys_clk = 1'b0;
    logic                    srst = 1'b1;
    pmcp_pkg::pmcp_cpu_req_t cpu_req = '0;
    pmcp_pkg::pmcp_pgm_req_t pgm_req = '0;
    logic                    pin_lv = 1'b0;
    logic                    pin_hv = 1'b0;
    logic [7:0]              mem_rdata;
    logic [7:0]              pgm_mem_rdata;
    pmcp_pkg::pmcp_rsp_t     cpu_rsp;
    pmcp_pkg::pmcp_rsp_t     pgm_rsp;
    logic                    prog_mode;
    logic                    prog_pin_is_gpio;
    logic                    debug_enable;
    logic                    ee_cpu_allow;
    int                      fail_count = 0;
    int                      samples_checked = 0;

    // 10 MHz core clock
    always #50 sys_clk = ~sys_clk;

    pmcp_guard pmcp_guard_i (.sys_clk(sys_clk), .srst(srst), .cpu_req(cpu_req),
        .mem_rdata(mem_rdata), .pgm_req(pgm_req), .pgm_mem_rdata(pgm_mem_rdata),
        .prog_entry_pin(pin_lv), .master_clear_prog_voltage_pin(pin_hv),
        .cpu_rsp(cpu_rsp), .pgm_rsp(pgm_rsp), .prog_mode(prog_mode),
        .prog_pin_is_gpio(prog_pin_is_gpio), .debug_enable(debug_enable),
        .ee_cpu_allow(ee_cpu_allow));
    pmcp_mem_model pmcp_mem_model_i (.cpu_addr(cpu_req.addr), .pgm_addr(pgm_req.addr),
        .pgm_ee(pgm_req.ee), .cpu_data(mem_rdata), .pgm_data(pgm_mem_rdata));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected flash byte, worked out independently of the model
    function automatic logic [7:0] md(input logic [21:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One CPU table access, judged in the cycle after it is taken
    task automatic cpu(input logic w, input logic [21:0] a, input logic [21:0] p,
                       input logic [7:0] d, input logic ok, input logic [7:0] rd);
        @(negedge sys_clk);
        cpu_req = {1'b1, w, a, p, d};
        @(negedge sys_clk);
        cpu_req.valid = 1'b0;
        chk({7'h0, cpu_rsp.ack}, 8'h01);
        chk({7'h0, cpu_rsp.allow}, {7'h0, ok});
        chk(cpu_rsp.rdata, rd);
    endtask
    // One programmer request; ack is expected only inside a session
    task automatic pgm(input logic w, input logic ee, input logic ce, input logic be,
                       input logic [2:0] b, input logic [21:0] a, input logic [7:0] d,
                       input logic ak, input logic ok, input logic [7:0] rd);
        @(negedge sys_clk);
        pgm_req = {1'b1, w, ee, ce, be, b, a, d};
        @(negedge sys_clk);
        pgm_req.valid = 1'b0;
        chk({7'h0, pgm_rsp.ack}, {7'h0, ak});
        chk({7'h0, pgm_rsp.allow}, {7'h0, ok});
        chk(pgm_rsp.rdata, rd);
    endtask
    task automatic cr(input logic [21:0] a, input logic [7:0] e);
        cpu(1'b0, a, 22'h000000, 8'h00, 1'b1, e);
    endtask
    task automatic cw(input logic [21:0] a, input logic [7:0] d, input logic ok);
        cpu(1'b1, a, 22'h000000, d, ok, 8'h00);
    endtask
    task automatic pw(input logic [21:0] a, input logic [7:0] d, input logic ok);
        pgm(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, a, d, 1'b1, ok, 8'h00);
    endtask
    task automatic pr(input logic [21:0] a, input logic ok, input logic [7:0] e);
        pgm(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, a, 8'h00, 1'b1, ok, e);
    endtask

    // Erased part: implemented bits read 1, the rest 0
    task automatic t_reset();
        logic [7:0] ers [8] = '{8'h84, 8'h00, 8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
        wt(2);
        chk({5'h0, ee_cpu_allow, debug_enable, prog_pin_is_gpio}, 8'h04);
        for (int i = 0; i < 8; i++) begin
            cr(22'h300006 + 22'(i), ers[i]);
        end
        // No session yet: the programmer request must go unanswered
        pgm(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 22'h200000, 8'h00, 1'b0, 1'b0, 8'h00);
        $display("test reset values done");
    endtask
    // Table access reach: IDs, device ID, unimplemented space
    task automatic t_map();
        cpu(1'b0, 22'h200007, 22'h000100, 8'h00, 1'b1, md(22'h200007));
        cpu(1'b1, 22'h200000, 22'h000100, 8'h12, 1'b1, 8'h00);
        cpu(1'b0, 22'h3ffffe, 22'h000100, 8'h00, 1'b1, md(22'h3ffffe));
        cpu(1'b1, 22'h3fffff, 22'h000100, 8'h12, 1'b0, 8'h00);
        cpu(1'b0, 22'h006abc, 22'h000000, 8'h00, 1'b1, md(22'h006abc));
        cpu(1'b0, 22'h008000, 22'h000100, 8'h00, 1'b1, 8'h00);
        $display("test address map done");
    endtask
    // Table-read protection at block edges, then a failed attempt to set a bit
    task automatic t_trp();
        cw(22'h30000c, 8'h0b, 1'b1);
        cpu(1'b0, 22'h004000, 22'h003fff, 8'h00, 1'b0, 8'h00);
        cpu(1'b0, 22'h005fff, 22'h004000, 8'h00, 1'b1, md(22'h005fff));
        cw(22'h30000d, 8'h00, 1'b1);
        cpu(1'b0, 22'h0001ff, 22'h000200, 8'h00, 1'b0, 8'h00);
        cpu(1'b0, 22'h000000, 22'h0001ff, 8'h00, 1'b1, md(22'h000000));
        cw(22'h30000c, 8'hff, 1'b1);
        cr(22'h30000c, 8'h0b);
        $display("test table read protect done");
    endtask
    // Write protection of block 0 and boot; config bit survives CPU writes
    task automatic t_wp();
        cw(22'h30000a, 8'h0e, 1'b1);
        cpu(1'b1, 22'h000200, 22'h000000, 8'h33, 1'b0, 8'h00);
        cpu(1'b1, 22'h001fff, 22'h000000, 8'h33, 1'b0, 8'h00);
        cpu(1'b1, 22'h002000, 22'h000000, 8'h33, 1'b1, 8'h00);
        cw(22'h30000b, 8'h00, 1'b1);
        cr(22'h30000b, 8'h20);
        cpu(1'b1, 22'h000100, 22'h000000, 8'h33, 1'b0, 8'h00);
        $display("test write protect done");
    endtask
    // Low-voltage entry; the low-voltage bit must not change in this session
    task automatic t_lv();
        // Port pull-up on the entry pin is taken as off, so the bench drives it cleanly
        pin_lv = 1'b1;
        wt(8);
        chk({7'h0, prog_mode}, 8'h01);
        pw(22'h300006, 8'h80, 1'b1);
        cr(22'h300006, 8'h84);
        pin_lv = 1'b0;
        wt(8);
        chk({7'h0, prog_mode}, 8'h00);
        $display("test low voltage entry done");
    endtask
    // High-voltage session: programmer-side protection, fuses and erases
    task automatic t_hv();
        pin_hv = 1'b1;
        wt(8);
        chk({7'h0, prog_mode}, 8'h01);
        pr(22'h002000, 1'b1, 8'h5a);
        pw(22'h300008, 8'h0d, 1'b1);
        pr(22'h002000, 1'b0, 8'h00);
        pw(22'h002000, 8'h44, 1'b0);
        cpu(1'b0, 22'h002000, 22'h000000, 8'h00, 1'b1, 8'h5a);
        pgm(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 22'h000010, 8'h00, 1'b1, 1'b1, 8'hb5);
        pgm(1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 22'h000010, 8'h77, 1'b1, 1'b0, 8'h00);
        pw(22'h300009, 8'h40, 1'b1);
        pgm(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 22'h000010, 8'h00, 1'b1, 1'b0, 8'h00);
        chk({7'h0, ee_cpu_allow}, 8'h01);
        pr(22'h200000, 1'b1, 8'h5a);
        pw(22'h30000b, 8'h00, 1'b1);
        cw(22'h30000c, 8'h00, 1'b0);
        cr(22'h30000c, 8'h0b);
        pw(22'h300006, 8'h00, 1'b1);
        wt(8);
        chk({6'h0, debug_enable, prog_pin_is_gpio}, 8'h03);
        pin_hv = 1'b0;
        pin_lv = 1'b1;
        wt(8);
        chk({7'h0, prog_mode}, 8'h00);
        pin_lv = 1'b0;
        pin_hv = 1'b1;
        wt(8);
        // Erase carries a read of address 0, whose block is still readable
        pgm(1'b0, 1'b0, 1'b0, 1'b1, 3'h1, 22'h0, 8'h00, 1'b1, 1'b1, 8'h5a);
        cr(22'h300008, 8'h0f);
        pgm(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 22'h0, 8'h00, 1'b1, 1'b1, 8'h5a);
        cr(22'h30000b, 8'he0);
        cr(22'h300006, 8'h84);
        cr(22'h30000c, 8'h0f);
        pin_hv = 1'b0;
        $display("test high voltage session done");
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Reset held for 20 cycles, then the scenarios in order
    initial begin
        wt(20);
        srst = 1'b0;
        t_reset();
        t_map();
        t_trp();
        t_wp();
        t_lv();
        t_hv();
        print_verdict();
    end

    // The run needs about 175 cycles; over fifteen times that means a hang
    initial begin
        wt(3000);
        fail_count++;
        print_verdict();
    end
endmodule // test_program_memory_code_protection
`default_nettype wire
